/* File: logic/ecx_bus_timer.sv */
`timescale 1ns/10ps
`include "ecx_regs.svh"
module ecx_bus_timer
  import ecx_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // Bus request and end of cycle
  input wire ecx_bus_s i_req,
  output logic o_done
);
  ecx_tmr_s t_r, t_nxt;
  logic [1:0] last;
  logic slow;

  assign slow = ecx_is_slow(i_req.addr);
  assign last = slow ? `ECX_LAST_SLOW : `ECX_LAST_FAST;
  assign o_done = i_req.valid && t_r.cnt == last;

  always_comb begin
    t_nxt = t_r;
    if (!i_req.valid || o_done) begin
      t_nxt.cnt = 2'h0;
    end else begin
      t_nxt.cnt = t_r.cnt + 2'h1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      t_r <= '0;
    end else begin
      t_r <= t_nxt;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_start;
    i_req.valid && t_r.cnt == 2'h0;
  endsequence
  chk_fast_two_states: assert property (s_start ##0 !slow |=> o_done)
    else $error("fast access did not end in two states");
  chk_slow_three_states: assert property (s_start ##0 slow |=> !o_done ##1 o_done)
    else $error("slow access did not end in three states");
  chk_periph_byte_only: assert property (i_req.valid && ecx_is_periph(i_req.addr) |-> !i_req.word)
    else $error("word access reached a peripheral");
endmodule

/* File: logic/ecx_cond_eval.sv */
`timescale 1ns/10ps
`include "ecx_regs.svh"
module ecx_cond_eval
  import ecx_pkg::*;
(
  // Condition and flags
  input wire ecx_cond_e i_cond,
  input wire logic [7:0] i_ccr,
  // Result
  output logic o_taken
);
  logic c, z, v, n;
  assign c = i_ccr[`ECX_CCR_C];
  assign z = i_ccr[`ECX_CCR_Z];
  assign v = i_ccr[`ECX_CCR_V];
  assign n = i_ccr[`ECX_CCR_N];

  always_comb begin
    unique case (i_cond)
      CC_T: o_taken = 1'b1;
      CC_F: o_taken = 1'b0;
      CC_HI: o_taken = ~(c | z);
      CC_LS: o_taken = c | z;
      CC_HS: o_taken = ~c;
      CC_LO: o_taken = c;
      CC_NE: o_taken = ~z;
      CC_EQ: o_taken = z;
      CC_VC: o_taken = ~v;
      CC_VS: o_taken = v;
      CC_PL: o_taken = ~n;
      CC_MI: o_taken = n;
      CC_GE: o_taken = ~(n ^ v);
      CC_LT: o_taken = n ^ v;
      CC_GT: o_taken = ~(z | (n ^ v));
      CC_LE: o_taken = z | (n ^ v);
    endcase
  end
endmodule

/* File: logic/ecx_core.sv */
`timescale 1ns/10ps
`include "ecx_regs.svh"
module ecx_core
  import ecx_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // Instruction issue
  input wire logic i_op_valid,
  input wire ecx_instr_s i_op,
  output logic o_op_ready,
  output logic o_op_done,
  // Flag store result
  output logic o_gpr_wr,
  output logic [7:0] o_gpr_wdata,
  // Interrupt request
  input wire logic i_irq,
  input wire logic [15:0] i_irq_vec,
  // Internal bus
  output ecx_bus_s o_bus,
  input wire logic [15:0] i_bus_rdata,
  // Register port
  input wire logic [2:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [15:0] o_reg_rdata,
  // Status
  output ecx_cpu_e o_cpu_state,
  output ecx_halt_e o_halt_mode,
  output logic o_use_subclk,
  output logic [15:0] o_pc,
  output logic [7:0] o_ccr
);
  ecx_core_s s_r, s_nxt;
  logic taken;
  logic bus_done;
  logic take_irq;
  logic accept;
  logic [15:0] sp_dn;
  logic [15:0] sp_up;
  logic [15:0] pc_nx;
  logic [15:0] disp;
  logic [15:0] stat;

  // ==========================================
  // Helpers
  ecx_cond_eval u_cond (
    .i_cond(i_op.cond),
    .i_ccr(s_r.condition_flag_register),
    .o_taken(taken)
  );

  ecx_bus_timer u_tmr (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_req(s_r.bus),
    .o_done(bus_done)
  );

  // Peripherals see bytes only, so a word request there is narrowed
  function automatic ecx_bus_s bus_rq(input logic we, input logic word,
                                      input logic [15:0] a, input logic [15:0] d);
    ecx_bus_s b;
    b.valid = 1'b1;
    b.we = we;
    b.word = word & ~ecx_is_periph(a);
    b.addr = a;
    b.wdata = d;
    return b;
  endfunction

  assign sp_dn = s_r.sp - `ECX_STACK_STEP;
  assign sp_up = s_r.sp + `ECX_STACK_STEP;
  assign pc_nx = s_r.pc + `ECX_LEN_SHORT;
  assign disp = {{8{i_op.imm[7]}}, i_op.imm};
  // Halt wakes on any request; execution honours the mask bit
  assign take_irq = i_irq && ((s_r.st == S_EXEC && !s_r.condition_flag_register[`ECX_CCR_I])
                    || s_r.st == S_HALT);
  assign o_op_ready = s_r.st == S_EXEC && !take_irq;
  assign accept = i_op_valid && o_op_ready;

  always_comb begin
    stat = 16'h0000;
    stat[`ECX_STAT_CCR +: 8] = s_r.condition_flag_register;
    stat[`ECX_STAT_CPU +: 2] = o_cpu_state;
    stat[`ECX_STAT_HALT +: 3] = s_r.halt;
  end

  // ==========================================
  // CPU state
  always_comb begin
    unique case (s_r.st)
      S_RST: o_cpu_state = CPU_RESET;
      S_VEC, S_EPC, S_ECCR: o_cpu_state = CPU_EXC;
      S_HALT: o_cpu_state = CPU_HALT;
      S_EXEC, S_CALL, S_RTS, S_RCCR, S_RPC, S_BRD, S_BWR: o_cpu_state = CPU_EXEC;
    endcase
  end

  // ==========================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.gpr_wr = 1'b0;
    s_nxt.done = 1'b0;
    s_nxt.rdata = 16'h0000;
    if (i_reg_rd) begin
      case (i_reg_addr)
        `ECX_REG_CTRL: begin
          s_nxt.rdata[`ECX_CTRL_EXEC +: 2] = s_r.exec;
          s_nxt.rdata[`ECX_CTRL_HALT +: 3] = s_r.halt;
        end
        `ECX_REG_STAT: s_nxt.rdata = stat;
        `ECX_REG_SP: s_nxt.rdata = s_r.sp;
        `ECX_REG_PC: s_nxt.rdata = s_r.pc;
        `ECX_REG_CNT: s_nxt.rdata = {8'h00, s_r.cnt};
        `ECX_REG_SRC: s_nxt.rdata = s_r.src;
        `ECX_REG_DST: s_nxt.rdata = s_r.dst;
        default: s_nxt.rdata = 16'h0000;
      endcase
    end
    if (i_reg_wr && i_reg_addr == `ECX_REG_CTRL) begin
      s_nxt.exec = ecx_exec_e'(i_reg_wdata[`ECX_CTRL_EXEC +: 2]);
      s_nxt.halt = ecx_halt_e'(i_reg_wdata[`ECX_CTRL_HALT +: 3]);
    end
    if (i_reg_wr && i_reg_addr == `ECX_REG_SP) begin
      s_nxt.sp = i_reg_wdata;
    end
    if (bus_done) begin
      s_nxt.bus.valid = 1'b0;
    end
    if (take_irq) begin
      s_nxt.sp = sp_dn;
      s_nxt.bus = bus_rq(1'b1, 1'b1, sp_dn, s_r.pc);
      s_nxt.vec = i_irq_vec;
      s_nxt.st = S_EPC;
    end else begin
      unique case (s_r.st)
        S_RST: begin
          s_nxt.bus = bus_rq(1'b0, 1'b1, `ECX_RESET_VEC, 16'h0000);
          s_nxt.st = S_VEC;
        end
        S_VEC: begin
          if (bus_done) begin
            s_nxt.pc = i_bus_rdata;
            s_nxt.st = S_EXEC;
          end
        end
        S_EXEC: begin
          if (accept) begin
            s_nxt.pc = pc_nx;
            s_nxt.done = 1'b1;
            unique case (i_op.op)
              OP_NOP: s_nxt.pc = pc_nx;
              OP_BCC: begin
                if (taken) begin
                  s_nxt.pc = pc_nx + disp;
                end
              end
              OP_JMP: s_nxt.pc = i_op.target;
              OP_BSR, OP_JSR: begin
                s_nxt.done = 1'b0;
                s_nxt.sp = sp_dn;
                s_nxt.st = S_CALL;
                if (i_op.op == OP_BSR) begin
                  s_nxt.pc = pc_nx + disp;
                  s_nxt.bus = bus_rq(1'b1, 1'b1, sp_dn, pc_nx);
                end else begin
                  s_nxt.pc = i_op.target;
                  s_nxt.bus = bus_rq(1'b1, 1'b1, sp_dn, s_r.pc + `ECX_LEN_LONG);
                end
              end
              OP_RTS: begin
                s_nxt.done = 1'b0;
                s_nxt.bus = bus_rq(1'b0, 1'b1, s_r.sp, 16'h0000);
                s_nxt.st = S_RTS;
              end
              OP_RTE: begin
                s_nxt.done = 1'b0;
                s_nxt.bus = bus_rq(1'b0, 1'b1, s_r.sp, 16'h0000);
                s_nxt.st = S_RCCR;
              end
              OP_SLEEP: s_nxt.st = S_HALT;
              OP_LDCI: s_nxt.condition_flag_register = i_op.imm;
              OP_LDCR: s_nxt.condition_flag_register = i_op.gpr_val;
              OP_STC: begin
                s_nxt.gpr_wr = 1'b1;
                s_nxt.gpr_data = s_r.condition_flag_register;
              end
              OP_FLAG_AND_INSTR: s_nxt.condition_flag_register = s_r.condition_flag_register & i_op.imm;
              OP_ORC: s_nxt.condition_flag_register = s_r.condition_flag_register | i_op.imm;
              OP_FLAG_XOR_INSTR: s_nxt.condition_flag_register = s_r.condition_flag_register ^ i_op.imm;
              OP_BLKMV: begin
                s_nxt.pc = s_r.pc + `ECX_LEN_LONG;
                s_nxt.cnt = i_op.count;
                s_nxt.src = i_op.src;
                s_nxt.dst = i_op.dst;
                if (i_op.count != 8'h00) begin
                  s_nxt.done = 1'b0;
                  s_nxt.bus = bus_rq(1'b0, 1'b0, i_op.src, 16'h0000);
                  s_nxt.st = S_BRD;
                end
              end
            endcase
          end
        end
        S_CALL: begin
          if (bus_done) begin
            s_nxt.done = 1'b1;
            s_nxt.st = S_EXEC;
          end
        end
        S_EPC: begin
          if (bus_done) begin
            s_nxt.sp = sp_dn;
            s_nxt.bus = bus_rq(1'b1, 1'b1, sp_dn, {s_r.condition_flag_register, s_r.condition_flag_register});
            s_nxt.st = S_ECCR;
          end
        end
        S_ECCR: begin
          if (bus_done) begin
            s_nxt.condition_flag_register[`ECX_CCR_I] = 1'b1;
            s_nxt.pc = s_r.vec;
            s_nxt.st = S_EXEC;
          end
        end
        S_RTS, S_RPC: begin
          if (bus_done) begin
            s_nxt.pc = i_bus_rdata;
            s_nxt.sp = sp_up;
            s_nxt.done = 1'b1;
            s_nxt.st = S_EXEC;
          end
        end
        S_RCCR: begin
          if (bus_done) begin
            s_nxt.condition_flag_register = i_bus_rdata[15:8];
            s_nxt.sp = sp_up;
            s_nxt.bus = bus_rq(1'b0, 1'b1, sp_up, 16'h0000);
            s_nxt.st = S_RPC;
          end
        end
        S_BRD: begin
          if (bus_done) begin
            s_nxt.tmp = i_bus_rdata[7:0];
            s_nxt.bus = bus_rq(1'b1, 1'b0, s_r.dst, {8'h00, i_bus_rdata[7:0]});
            s_nxt.st = S_BWR;
          end
        end
        S_BWR: begin
          if (bus_done) begin
            s_nxt.src = s_r.src + 16'h0001;
            s_nxt.dst = s_r.dst + 16'h0001;
            s_nxt.cnt = s_r.cnt - 8'h01;
            if (s_r.cnt == 8'h01) begin
              s_nxt.done = 1'b1;
              s_nxt.st = S_EXEC;
            end else begin
              s_nxt.bus = bus_rq(1'b0, 1'b0, s_r.src + 16'h0001, 16'h0000);
              s_nxt.st = S_BRD;
            end
          end
        end
        S_HALT: s_nxt.st = S_HALT;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_r <= '0;
      s_r.st <= S_RST;
      s_r.sp <= `ECX_SP_RST;
      s_r.condition_flag_register <= `ECX_CCR_RST;
      s_r.exec <= EM_HIGH;
      s_r.halt <= HM_SLEEP_HIGH;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================
  // Outputs
  assign o_op_done = s_r.done;
  assign o_gpr_wr = s_r.gpr_wr;
  assign o_gpr_wdata = s_r.gpr_data;
  assign o_bus = s_r.bus;
  assign o_reg_rdata = s_r.rdata;
  assign o_halt_mode = s_r.halt;
  assign o_use_subclk = s_r.exec == EM_SUB;
  assign o_pc = s_r.pc;
  assign o_ccr = s_r.condition_flag_register;

  // ==========================================
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_pc_saved;
    o_bus.valid && o_bus.we && o_bus.word;
  endsequence

  chk_nop_pc_step: assert property (accept && i_op.op == OP_NOP
    |=> o_pc == $past(o_pc) + `ECX_LEN_SHORT && o_op_done)
    else $error("no-operation did not advance pc by two");
  chk_eq_not_taken: assert property (accept && i_op.op == OP_BCC && i_op.cond == CC_EQ
    && !s_r.condition_flag_register[`ECX_CCR_Z] |=> o_pc == $past(o_pc) + `ECX_LEN_SHORT)
    else $error("equal branch taken with zero flag clear");
  chk_flag_and: assert property (accept && i_op.op == OP_FLAG_AND_INSTR
    |=> o_ccr == ($past(o_ccr) & $past(i_op.imm)))
    else $error("flag and result wrong");
  chk_flag_store: assert property (accept && i_op.op == OP_STC
    |=> o_gpr_wr && o_gpr_wdata == $past(o_ccr))
    else $error("flag store wrong");
  chk_sleep_halt: assert property (accept && i_op.op == OP_SLEEP
    |=> o_cpu_state == CPU_HALT)
    else $error("sleep did not halt");
  chk_blk_empty: assert property (accept && i_op.op == OP_BLKMV && i_op.count == 8'h00
    |=> o_op_done && !o_bus.valid)
    else $error("empty block move touched the bus");
  chk_irq_push_order: assert property (take_irq
    |=> s_pc_saved ##0 o_bus.addr == $past(s_r.sp) - `ECX_STACK_STEP
    ##[1:3] s_r.st == S_ECCR ##[1:3] s_r.condition_flag_register[`ECX_CCR_I])
    else $error("interrupt entry sequence wrong");
  chk_return_pop: assert property (accept && i_op.op == OP_RTS
    |=> !o_bus.we && o_bus.addr == $past(s_r.sp)
    ##2 s_r.sp == $past(s_r.sp, 3) + `ECX_STACK_STEP)
    else $error("return pop wrong");
  chk_call_push: assert property (accept && (i_op.op == OP_BSR || i_op.op == OP_JSR)
    |=> o_bus.we && o_bus.addr == $past(s_r.sp) - `ECX_STACK_STEP ##[2:3] o_op_done)
    else $error("call push wrong");
  chk_rte_restore: assert property (accept && i_op.op == OP_RTE
    |=> !o_bus.we && o_bus.addr == $past(s_r.sp)
    ##[2:3] s_r.st == S_RPC && o_bus.valid && o_bus.addr == s_r.sp)
    else $error("exception return pop order wrong");
  chk_blk_count: assert property (s_r.st == S_BWR && bus_done
    |=> s_r.cnt == $past(s_r.cnt) - 8'h01)
    else $error("block move count did not step");
  chk_flag_load: assert property (accept && i_op.op == OP_LDCI
    |=> o_ccr == $past(i_op.imm))
    else $error("flag load wrong");
endmodule

/* File: logic/ecx_pkg.sv */
`include "ecx_regs.svh"
package ecx_pkg;
  typedef enum logic [3:0] {
    OP_NOP, OP_BCC, OP_JMP, OP_BSR, OP_JSR, OP_RTS, OP_RTE, OP_SLEEP,
    OP_LDCI, OP_LDCR, OP_STC, OP_FLAG_AND_INSTR, OP_ORC, OP_FLAG_XOR_INSTR, OP_BLKMV
  } ecx_op_e;
  typedef enum logic [3:0] {
    CC_T, CC_F, CC_HI, CC_LS, CC_HS, CC_LO, CC_NE, CC_EQ,
    CC_VC, CC_VS, CC_PL, CC_MI, CC_GE, CC_LT, CC_GT, CC_LE
  } ecx_cond_e;
  typedef enum logic [1:0] {CPU_RESET, CPU_EXEC, CPU_HALT, CPU_EXC} ecx_cpu_e;
  typedef enum logic [1:0] {EM_HIGH, EM_MEDIUM, EM_SUB} ecx_exec_e;
  typedef enum logic [2:0] {
    HM_SLEEP_HIGH, HM_SLEEP_MED, HM_STANDBY, HM_WATCH, HM_SUBSLEEP
  } ecx_halt_e;
  typedef enum {
    S_RST, S_VEC, S_EXEC, S_CALL, S_EPC, S_ECCR, S_RTS, S_RCCR, S_RPC,
    S_BRD, S_BWR, S_HALT
  } ecx_fsm_e;
  typedef struct packed {
    ecx_op_e op;
    ecx_cond_e cond;
    logic [7:0] imm;
    logic [7:0] gpr_val;
    logic [15:0] target;
    logic [7:0] count;
    logic [15:0] src;
    logic [15:0] dst;
  } ecx_instr_s;
  typedef struct packed {
    logic valid;
    logic we;
    logic word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ecx_bus_s;
  typedef struct packed {
    logic [1:0] cnt;
  } ecx_tmr_s;
  typedef struct packed {
    ecx_fsm_e st;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [7:0] condition_flag_register;
    logic [7:0] cnt;
    logic [15:0] src;
    logic [15:0] dst;
    logic [7:0] tmp;
    logic [15:0] vec;
    ecx_exec_e exec;
    ecx_halt_e halt;
    ecx_bus_s bus;
    logic gpr_wr;
    logic [7:0] gpr_data;
    logic done;
    logic [15:0] rdata;
  } ecx_core_s;

  function automatic logic ecx_is_slow(input logic [15:0] a);
    return a >= `ECX_IO_SLOW_LO && a <= `ECX_IO_SLOW_HI;
  endfunction
  function automatic logic ecx_is_periph(input logic [15:0] a);
    return ecx_is_slow(a) || a >= `ECX_IO_FAST_LO;
  endfunction
endpackage

/* File: logic/ecx_regs.svh */
`ifndef ECX_REGS_SVH
`define ECX_REGS_SVH
// Contract
// - Conditional branch jumps only when its condition holds; signed tests use N xor V
// - HI/LS test C or Z; CC/CS test C; NE/EQ Z; VC/VS V; PL/MI N
// - Exception return restores saved flags and program counter
// - Sleep moves the CPU from active into a power-down mode
// - Flag load writes the flag register from immediate or general register
// - Flag store copies the whole flag register to a general register
// - AND, OR, XOR of flag register with immediate byte
// - No-operation only advances the program counter by two
// - Block move copies count bytes source to destination, nothing when count zero
// - One state is one clock period; a bus cycle lasts two or three states
// - On-chip memory takes two states over 16 bits, byte or word
// - Peripherals are byte only over 8 bits in two or three states
// - Four CPU states: reset, execution, halt, exception handling
// - Subactive mode runs from the subclock, active modes from system clock
// - Halt offers high and medium sleep, standby, watch and subsleep
// - Reset and interrupt enter exception handling; interrupt pushes PC and flags

// ==========================================
// Flag register bits
`define ECX_CCR_I 7
`define ECX_CCR_N 3
`define ECX_CCR_Z 2
`define ECX_CCR_V 1
`define ECX_CCR_C 0
`define ECX_CCR_RST 8'h80

// ==========================================
// Register port indexes and fields
`define ECX_REG_CTRL 3'h0
`define ECX_REG_STAT 3'h1
`define ECX_REG_SP 3'h2
`define ECX_REG_PC 3'h3
`define ECX_REG_CNT 3'h4
`define ECX_REG_SRC 3'h5
`define ECX_REG_DST 3'h6
`define ECX_CTRL_EXEC 0
`define ECX_CTRL_HALT 2
`define ECX_STAT_CCR 0
`define ECX_STAT_CPU 8
`define ECX_STAT_HALT 10
`define ECX_SP_RST 16'h0000

// ==========================================
// Addresses, lengths and bus timing
`define ECX_RESET_VEC 16'h0000
`define ECX_LEN_SHORT 16'h0002
`define ECX_LEN_LONG 16'h0004
`define ECX_STACK_STEP 16'h0002
`define ECX_IO_SLOW_LO 16'hF700
`define ECX_IO_SLOW_HI 16'hF7FF
`define ECX_IO_FAST_LO 16'hFF80
`define ECX_LAST_FAST 2'h1
`define ECX_LAST_SLOW 2'h2
`endif

/* File: verif/ecx_mem_model.sv */
`timescale 1ns/10ps
`include "ecx_regs.svh"
module ecx_mem_model
  import ecx_pkg::*;
(
  // Clock
  input wire logic i_ref_clk,
  // Internal bus
  input wire ecx_bus_s i_bus,
  output logic [15:0] o_rdata,
  output logic o_wide_periph
);
  logic [7:0] mem [0:65535];
  logic [15:0] last_r = 16'h0000;
  logic [15:0] a;
  logic periph;
  logic wide_r = 1'b0;
  assign a = i_bus.addr;
  assign periph = (a >= `ECX_IO_SLOW_LO && a <= `ECX_IO_SLOW_HI) || a >= `ECX_IO_FAST_LO;
  assign o_wide_periph = wide_r;
  // ==========================================
  // Read lanes; a released bus shows a changing pattern
  always_comb begin
    if (i_bus.valid && !i_bus.we) begin
      if (i_bus.word) begin
        o_rdata = {mem[{a[15:1], 1'b0}], mem[{a[15:1], 1'b1}]};
      end else begin
        o_rdata = {8'h00, mem[a]};
      end
    end else begin
      o_rdata = ~last_r;
    end
  end
  // ==========================================
  // Writes, and a flag for word accesses to peripherals
  always @(posedge i_ref_clk) begin
    last_r <= o_rdata;
    if (i_bus.valid && i_bus.word && periph) begin
      wide_r <= 1'b1;
    end
    if (i_bus.valid && i_bus.we) begin
      if (i_bus.word) begin
        mem[{a[15:1], 1'b0}] <= i_bus.wdata[15:8];
        mem[{a[15:1], 1'b1}] <= i_bus.wdata[7:0];
      end else begin
        mem[a] <= i_bus.wdata[7:0];
      end
    end
  end
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/10ps
`include "ecx_regs.svh"
`define chk_eq(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("mismatch %s expected %h seen %h", what, exp, got); end end
module testbench
  import ecx_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic op_valid = 1'b0;
  logic irq = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] irq_vec = 16'h0400;
  ecx_instr_s op = '0;
  ecx_instr_s ins = '0;
  logic op_ready, op_done, gpr_wr, use_subclk, wide;
  logic [7:0] gpr_wdata, condition_flag_register, eccr;
  logic [15:0] bus_rdata, reg_rdata, pc, rd, epc, esp, ret, ctl;
  ecx_bus_s bus;
  ecx_cpu_e cpu_state;
  ecx_halt_e halt_mode;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;

  always #20 clk = ~clk;

  ecx_core ecx_core_i (.i_ref_clk(clk), .i_arst_n(arst_n), .i_op_valid(op_valid), .i_op(op),
    .o_op_ready(op_ready), .o_op_done(op_done), .o_gpr_wr(gpr_wr), .o_gpr_wdata(gpr_wdata),
    .i_irq(irq), .i_irq_vec(irq_vec), .o_bus(bus), .i_bus_rdata(bus_rdata),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .o_reg_rdata(reg_rdata), .o_cpu_state(cpu_state), .o_halt_mode(halt_mode),
    .o_use_subclk(use_subclk), .o_pc(pc), .o_ccr(condition_flag_register));
  ecx_mem_model mem_i (.i_ref_clk(clk), .i_bus(bus), .o_rdata(bus_rdata), .o_wide_periph(wide));

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ==========================================
  // Access tasks
  function automatic logic [15:0] word_at(input logic [15:0] a);
    return {mem_i.mem[a], mem_i.mem[a + 16'h0001]};
  endfunction

  function automatic logic cond_true(input ecx_cond_e c, input logic [3:0] f);
    logic nv;
    nv = f[3] ^ f[1];
    case (c)
      CC_T: return 1'b1;
      CC_F: return 1'b0;
      CC_HI: return !(f[0] | f[2]);
      CC_LS: return f[0] | f[2];
      CC_HS: return !f[0];
      CC_LO: return f[0];
      CC_NE: return !f[2];
      CC_EQ: return f[2];
      CC_VC: return !f[1];
      CC_VS: return f[1];
      CC_PL: return !f[3];
      CC_MI: return f[3];
      CC_GE: return !nv;
      CC_LT: return nv;
      CC_GT: return !(f[2] | nv);
      default: return f[2] | nv;
    endcase
  endfunction

  task automatic reg_write(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(negedge clk);
  endtask

  task automatic reg_read(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  // Waits for done when lat is not negative, checks the latency when positive
  task automatic issue(input int lat);
    int n;
    n = 0;
    @(posedge clk);
    op <= ins;
    op_valid <= 1'b1;
    do begin @(negedge clk); n++; end while (op_ready !== 1'b1 && n < 100);
    @(posedge clk);
    op_valid <= 1'b0;
    n = 0;
    if (lat >= 0) begin
      do begin @(negedge clk); n++; end while (op_done !== 1'b1 && n < 100);
      if (lat > 0) `chk_eq("latency", lat, n)
    end
  endtask

  task automatic flag_op(input ecx_op_e o, input logic [7:0] v, input logic [7:0] e);
    ins.op = o;
    ins.imm = v;
    ins.gpr_val = v;
    issue(1);
    epc += 16'h0002;
    eccr = e;
    `chk_eq("pc", epc, pc)
    `chk_eq("flags", eccr, condition_flag_register)
  endtask

  task automatic ret_sub();
    ins.op = OP_RTS;
    issue(3);
    epc = ret;
    esp += 16'h0002;
    `chk_eq("return pc", epc, pc)
    reg_read(`ECX_REG_SP, rd);
    `chk_eq("sp after pop", esp, rd)
  endtask

  task automatic take_irq();
    int n;
    n = 0;
    @(posedge clk);
    irq <= 1'b1;
    do begin @(negedge clk); n++; end while (cpu_state !== CPU_EXC && n < 50);
    `chk_eq("exception state", CPU_EXC, cpu_state)
    @(posedge clk);
    irq <= 1'b0;
    do begin @(negedge clk); n++; end while (op_ready !== 1'b1 && n < 100);
    `chk_eq("vector pc", irq_vec, pc)
    `chk_eq("entry flags", eccr | 8'h80, condition_flag_register)
    `chk_eq("pushed pc", epc, word_at(esp - 16'h0002))
    `chk_eq("pushed flags", {eccr, eccr}, word_at(esp - 16'h0004))
    reg_read(`ECX_REG_SP, rd);
    `chk_eq("sp after entry", esp - 16'h0004, rd)
    ins.op = OP_RTE;
    issue(5);
    `chk_eq("resumed pc", epc, pc)
    `chk_eq("restored flags", eccr, condition_flag_register)
  endtask

  // ==========================================
  // Test sequence
  initial begin
    mem_i.mem[0] = 8'h01;
    mem_i.mem[1] = 8'h00;
    for (int i = 0; i < 3; i++) begin
      mem_i.mem[16'hFB00 + i] = 8'h11 * (i + 1);
      mem_i.mem[16'hFB40 + i] = 8'h00;
    end
    repeat (4) @(posedge clk);
    `chk_eq("reset state", CPU_RESET, cpu_state)
    `chk_eq("reset flags", 8'h80, condition_flag_register)
    arst_n <= 1'b1;
    for (int n = 0; n < 100 && op_ready !== 1'b1; n++) @(negedge clk);
    epc = 16'h0100;
    eccr = 8'h80;
    `chk_eq("vector fetch", epc, pc)
    reg_read(`ECX_REG_STAT, rd);
    `chk_eq("status", {CPU_EXEC, eccr}, rd[9:0])
    reg_read(3'h7, rd);
    `chk_eq("unmapped", 16'h0000, rd)
    reg_write(`ECX_REG_PC, 16'h1234);
    reg_read(`ECX_REG_PC, rd);
    `chk_eq("pc read only", epc, rd)
    esp = 16'hFC00;
    reg_write(`ECX_REG_SP, esp);
    flag_op(OP_LDCI, 8'h8F, 8'h8F);
    flag_op(OP_FLAG_AND_INSTR, 8'hA5, 8'h85);
    flag_op(OP_ORC, 8'h0A, 8'h8F);
    flag_op(OP_FLAG_XOR_INSTR, 8'h03, 8'h8C);
    flag_op(OP_LDCR, 8'h93, 8'h93);
    flag_op(OP_NOP, 8'h5A, 8'h93);
    flag_op(OP_STC, 8'h00, 8'h93);
    `chk_eq("store strobe", 1'b1, gpr_wr)
    `chk_eq("store data", eccr, gpr_wdata)
    for (int f = 0; f < 16; f++) begin
      flag_op(OP_LDCI, 8'h80 | 8'(f), 8'h80 | 8'(f));
      for (int c = 0; c < 16; c++) begin
        ins.op = OP_BCC;
        ins.cond = ecx_cond_e'(c);
        ins.imm = 8'hF0;
        issue(1);
        epc += cond_true(ins.cond, 4'(f)) ? 16'hFFF2 : 16'h0002;
        `chk_eq("branch pc", epc, pc)
      end
    end
    ins.op = OP_JSR;
    ins.target = 16'h0200;
    issue(3);
    ret = epc + 16'h0004;
    esp -= 16'h0002;
    epc = 16'h0200;
    `chk_eq("call pc", epc, pc)
    `chk_eq("call push", ret, word_at(esp))
    ret_sub();
    ins.op = OP_BSR;
    ins.imm = 8'h20;
    issue(3);
    ret = epc + 16'h0002;
    esp -= 16'h0002;
    epc += 16'h0022;
    `chk_eq("rel call pc", epc, pc)
    `chk_eq("rel call push", ret, word_at(esp))
    ret_sub();
    ins.op = OP_JMP;
    ins.target = 16'h0300;
    issue(1);
    epc = 16'h0300;
    `chk_eq("jump pc", epc, pc)
    flag_op(OP_LDCI, 8'h00, 8'h00);
    take_irq();
    ins.op = OP_BLKMV;
    ins.count = 8'h00;
    ins.src = 16'hFB00;
    ins.dst = 16'hFB40;
    issue(1);
    `chk_eq("empty move", 8'h00, mem_i.mem[16'hFB40])
    ins.count = 8'h03;
    issue(13);
    epc += 16'h0008;
    `chk_eq("move pc", epc, pc)
    for (int i = 0; i < 3; i++) `chk_eq("moved byte", 8'h11 * (i + 1), mem_i.mem[16'hFB40 + i])
    reg_read(`ECX_REG_CNT, rd);
    `chk_eq("count", 16'h0000, rd)
    reg_read(`ECX_REG_SRC, rd);
    `chk_eq("source", 16'hFB03, rd)
    reg_read(`ECX_REG_DST, rd);
    `chk_eq("dest", 16'hFB43, rd)
    ins.count = 8'h01;
    ins.dst = 16'hF700;
    issue(0);
    epc += 16'h0004;
    `chk_eq("periph move pc", epc, pc)
    `chk_eq("periph byte", 8'h11, mem_i.mem[16'hF700])
    for (int h = 0; h < 5; h++) begin
      ctl = {11'h000, 3'(h), h == 4 ? 2'(EM_SUB) : h == 1 ? 2'(EM_MEDIUM) : 2'(EM_HIGH)};
      reg_write(`ECX_REG_CTRL, ctl);
      reg_read(`ECX_REG_CTRL, rd);
      `chk_eq("ctrl", ctl, rd)
      `chk_eq("subclock", h == 4, use_subclk)
      `chk_eq("halt mode", ecx_halt_e'(h), halt_mode)
      ins.op = OP_SLEEP;
      issue(-1);
      epc += 16'h0002;
      for (int n = 0; n < 20 && cpu_state !== CPU_HALT; n++) @(negedge clk);
      `chk_eq("halted", CPU_HALT, cpu_state)
      take_irq();
    end
    `chk_eq("no wide periph", 1'b0, wide)
    end_of_test();
  end
endmodule
